// ==== rtl/pwc_pkg.sv ====
// constants, field layouts and carrier types of the pwm channel waveform block
// Contract
// - a 4-bit divisor select picks master_clock/2^n for codes 0..10, shared clock a for 11, shared clock b for 12, and no clock otherwise.
// - alignment select 0 gives a left-aligned period and 1 a center-aligned one.
// - start level select 0 starts each period low and 1 starts it high.
// - with update target 0 a buffered update value moves into the duty value at the next period start.
// - with update target 1 a buffered update value moves into the period value at the next period start.
// - the update buffer is write-only and never changes the running waveform in mid-period.
// - only the low 16 bits of duty, period, counter and update registers are kept; upper bits are ignored.
// - a left-aligned period lasts period value times the selected divisor in master clock cycles.
// - a center-aligned period lasts twice that.
// - enabling the channel through the global enable clears the counter.
// - in left alignment the counter clears on the tick after it reaches the period value minus one, starting a new period.
// - each shared clock divides a selected power-of-two tick by a factor: 0 stops it, 1 passes it, 2..255 divide.
// - a period flag is set when a period completes and cleared when software reads the flag register.
package pwc_pkg;
    // ****************************************************************
    // register map (byte addresses)
    // ****************************************************************
    localparam logic [7:0] OFF_MODE     = 8'h00;
    localparam logic [7:0] OFF_DUTY     = 8'h04;
    localparam logic [7:0] OFF_PERIOD   = 8'h08;
    localparam logic [7:0] OFF_COUNTER  = 8'h0c;
    localparam logic [7:0] OFF_UPDATE   = 8'h10;
    localparam logic [7:0] OFF_ENABLE   = 8'h14;
    localparam logic [7:0] OFF_DIVIDER  = 8'h18;
    localparam logic [7:0] OFF_FLAG     = 8'h1c;
    localparam logic [7:0] OFF_MASK     = 8'h20;

    // ****************************************************************
    // field positions and codes
    // ****************************************************************
    localparam int         MODE_SEL_LSB   = 0;
    localparam int         MODE_ALIGN_BIT = 8;
    localparam int         MODE_POL_BIT   = 9;
    localparam int         MODE_UPD_BIT   = 10;
    localparam int         ENA_BIT        = 0;
    localparam int         DIS_BIT        = 1;
    localparam int         DIV_A_LSB      = 0;
    localparam int         PRE_A_LSB      = 8;
    localparam int         DIV_B_LSB      = 16;
    localparam int         PRE_B_LSB      = 24;
    localparam int         PRE_W          = 10;
    localparam logic [3:0] SEL_MAX_POW    = 4'ha;
    localparam logic [3:0] SEL_CLK_A      = 4'hb;
    localparam logic [3:0] SEL_CLK_B      = 4'hc;
    localparam logic [1:0] RESP_OKAY      = 2'h0;
    localparam logic [1:0] RESP_SLVERR    = 2'h2;
    localparam logic [7:0] FACTOR_OFF     = 8'h00;
    localparam logic [7:0] FACTOR_PASS    = 8'h01;

    // ****************************************************************
    // carrier types
    // ****************************************************************
    typedef struct packed {
        logic       update_target_select;
        logic       start_level_select;
        logic       alignment_select;
        logic [3:0] clock_divisor_select;
    } pwc_mode_t;

    typedef struct packed {
        logic [3:0] prescale;
        logic [7:0] factor;
    } pwc_div_t;

    typedef enum logic {PWC_UP, PWC_DOWN} pwc_dir_t;
endpackage

// ==== rtl/pwc_channel.sv ====
// one pwm channel waveform generator with axi4-lite register slave
//
// Implementation choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
module pwc_channel #(
    parameter int CNT_W = 16
) (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite write address
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // axi4-lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read address
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // axi4-lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // waveform and interrupt
    output logic             pwm_out,
    output logic             irq
);
    // ****************************************************************
    // helpers
    // ****************************************************************
    initial begin
        if (CNT_W < 2 || CNT_W > 16) begin
            $error("CNT_W must be 2..16");
        end
    end

    localparam int PRE_W_L = pwc_pkg::PRE_W;

    // tick of master_clock/2^code from the free-running prescaler
    function automatic logic pow_tick(input logic [3:0] code, input logic [PRE_W_L-1:0] cnt);
        logic [PRE_W_L:0] mask;
        mask = (11'h001 << code) - 11'h001;
        return (cnt & mask[PRE_W_L-1:0]) == mask[PRE_W_L-1:0];
    endfunction

    function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] d,
                                               input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        return {a[7:2], 2'h0} == off;
    endfunction

    // ****************************************************************
    // prescaler and shared divided clocks
    // ****************************************************************
    logic [PRE_W_L-1:0] pre_r, pre_nxt;
    pwc_pkg::pwc_div_t  div_cfg [2];
    logic [1:0]         shared_tick;
    logic [31:0]        divider_r;

    assign div_cfg[0] = {divider_r[pwc_pkg::PRE_A_LSB +: 4], divider_r[pwc_pkg::DIV_A_LSB +: 8]};
    assign div_cfg[1] = {divider_r[pwc_pkg::PRE_B_LSB +: 4], divider_r[pwc_pkg::DIV_B_LSB +: 8]};

    always_comb begin
        pre_nxt = pre_r + 1'b1;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pre_r <= '0;
        end else begin
            pre_r <= pre_nxt;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_shared
            logic [7:0] dcnt_r, dcnt_nxt;
            logic       in_tick;
            always_comb begin
                in_tick        = pow_tick(div_cfg[g].prescale, pre_r);
                dcnt_nxt       = dcnt_r;
                shared_tick[g] = 1'b0;
                if (in_tick && div_cfg[g].factor != pwc_pkg::FACTOR_OFF) begin
                    if (div_cfg[g].factor == pwc_pkg::FACTOR_PASS ||
                        dcnt_r >= div_cfg[g].factor - 8'h01) begin
                        dcnt_nxt       = 8'h00;
                        shared_tick[g] = 1'b1;
                    end else begin
                        dcnt_nxt = dcnt_r + 8'h01;
                    end
                end
            end
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    dcnt_r <= 8'h00;
                end else begin
                    dcnt_r <= dcnt_nxt;
                end
            end
        end
    endgenerate

    // ****************************************************************
    // channel state and register slave
    // ****************************************************************
    pwc_pkg::pwc_mode_t mode_r, mode_nxt;
    pwc_pkg::pwc_dir_t  dir_r, dir_nxt;
    logic [CNT_W-1:0]   duty_r, duty_nxt, period_r, period_nxt, cnt_r, cnt_nxt;
    logic [CNT_W-1:0]   upd_r, upd_nxt;
    logic               pend_r, pend_nxt, en_r, en_nxt, flag_r, flag_nxt, mask_r, mask_nxt;
    logic               out_r, out_nxt, irq_r, irq_nxt;
    logic [31:0]        divider_nxt;
    logic               aw_held_r, aw_held_nxt, w_held_r, w_held_nxt;
    logic [7:0]         aw_addr_r, aw_addr_nxt, ar_a;
    logic [31:0]        w_data_r, w_data_nxt, rdata_r, rdata_nxt, wd, cur;
    logic [3:0]         w_strb_r, w_strb_nxt;
    logic               awready_r, awready_nxt, wready_r, wready_nxt, bvalid_r, bvalid_nxt;
    logic               arready_r, arready_nxt, rvalid_r, rvalid_nxt;
    logic [1:0]         bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic               chan_tick, tick, boundary, do_wr, do_rd;

    always_comb begin
        mode_nxt    = mode_r;
        dir_nxt     = dir_r;
        duty_nxt    = duty_r;
        period_nxt  = period_r;
        cnt_nxt     = cnt_r;
        upd_nxt     = upd_r;
        pend_nxt    = pend_r;
        en_nxt      = en_r;
        flag_nxt    = flag_r;
        mask_nxt    = mask_r;
        divider_nxt = divider_r;
        aw_held_nxt = aw_held_r;
        aw_addr_nxt = aw_addr_r;
        w_held_nxt  = w_held_r;
        w_data_nxt  = w_data_r;
        w_strb_nxt  = w_strb_r;
        bvalid_nxt  = bvalid_r;
        bresp_nxt   = bresp_r;
        rvalid_nxt  = rvalid_r;
        rdata_nxt   = rdata_r;
        rresp_nxt   = rresp_r;
        boundary    = 1'b0;
        wd          = 32'h0000_0000;
        cur         = 32'h0000_0000;
        ar_a        = s_axi_araddr;
        // clock source of the counter; reserved codes stall it
        unique case (1'b1)
            mode_r.clock_divisor_select <= pwc_pkg::SEL_MAX_POW:
                chan_tick = pow_tick(mode_r.clock_divisor_select, pre_r);
            mode_r.clock_divisor_select == pwc_pkg::SEL_CLK_A: chan_tick = shared_tick[0];
            mode_r.clock_divisor_select == pwc_pkg::SEL_CLK_B: chan_tick = shared_tick[1];
            default: chan_tick = 1'b0;
        endcase
        tick = en_r && chan_tick;
        if (tick) begin
            if (!mode_r.alignment_select) begin
                // period_value ticks, counter 0 .. period_value-1
                if (period_r == '0 || cnt_r >= period_r - CNT_W'(1)) begin
                    cnt_nxt  = '0;
                    boundary = 1'b1;
                end else begin
                    cnt_nxt = cnt_r + 1'b1;
                end
            end else if (dir_r == pwc_pkg::PWC_UP) begin
                if (period_r == '0) begin
                    boundary = 1'b1;
                end else if (cnt_r >= period_r) begin
                    cnt_nxt = cnt_r - 1'b1;
                    if (cnt_r == CNT_W'(1)) begin
                        boundary = 1'b1;
                    end else begin
                        dir_nxt = pwc_pkg::PWC_DOWN;
                    end
                end else begin
                    cnt_nxt = cnt_r + 1'b1;
                end
            end else begin
                cnt_nxt = cnt_r - 1'b1;
                if (cnt_r == CNT_W'(1)) begin
                    dir_nxt  = pwc_pkg::PWC_UP;
                    boundary = 1'b1;
                end
            end
        end
        // the buffer lands only at a period start
        if (boundary && pend_r) begin
            pend_nxt = 1'b0;
            if (mode_r.update_target_select) begin
                period_nxt = upd_r;
            end else begin
                duty_nxt = upd_r;
            end
        end
        // write channel: address and data taken in any order
        if (s_axi_awvalid && awready_r) begin
            aw_held_nxt = 1'b1;
            aw_addr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_r) begin
            w_held_nxt = 1'b1;
            w_data_nxt = s_axi_wdata;
            w_strb_nxt = s_axi_wstrb;
        end
        do_wr = aw_held_r && w_held_r && !bvalid_r;
        if (do_wr) begin
            wd          = strb_merge(32'h0000_0000, w_data_r, w_strb_r);
            aw_held_nxt = 1'b0;
            w_held_nxt  = 1'b0;
            bvalid_nxt  = 1'b1;
            bresp_nxt   = pwc_pkg::RESP_OKAY;
            unique case (1'b1)
                hit(aw_addr_r, pwc_pkg::OFF_MODE): begin
                    cur      = strb_merge({21'h0, mode_r[6:4], 4'h0, mode_r[3:0]}, w_data_r,
                                          w_strb_r);
                    mode_nxt = {cur[pwc_pkg::MODE_UPD_BIT], cur[pwc_pkg::MODE_POL_BIT],
                                cur[pwc_pkg::MODE_ALIGN_BIT], cur[pwc_pkg::MODE_SEL_LSB +: 4]};
                end
                hit(aw_addr_r, pwc_pkg::OFF_DUTY): begin
                    cur      = strb_merge(32'(duty_r), w_data_r, w_strb_r);
                    duty_nxt = cur[CNT_W-1:0];
                end
                hit(aw_addr_r, pwc_pkg::OFF_PERIOD): begin
                    cur        = strb_merge(32'(period_r), w_data_r, w_strb_r);
                    period_nxt = cur[CNT_W-1:0];
                end
                hit(aw_addr_r, pwc_pkg::OFF_UPDATE): begin
                    cur      = strb_merge(32'(upd_r), w_data_r, w_strb_r);
                    upd_nxt  = cur[CNT_W-1:0];
                    pend_nxt = 1'b1;
                end
                hit(aw_addr_r, pwc_pkg::OFF_ENABLE): begin
                    if (wd[pwc_pkg::DIS_BIT]) begin
                        en_nxt = 1'b0;
                    end
                    if (wd[pwc_pkg::ENA_BIT]) begin
                        en_nxt  = 1'b1;
                        cnt_nxt = '0;
                        dir_nxt = pwc_pkg::PWC_UP;
                    end
                end
                hit(aw_addr_r, pwc_pkg::OFF_DIVIDER):
                    divider_nxt = strb_merge(divider_r, w_data_r, w_strb_r);
                hit(aw_addr_r, pwc_pkg::OFF_FLAG): begin
                    if (wd[0]) begin
                        flag_nxt = 1'b0;
                    end
                end
                hit(aw_addr_r, pwc_pkg::OFF_MASK): mask_nxt = wd[0];
                hit(aw_addr_r, pwc_pkg::OFF_COUNTER): ;
                default: bresp_nxt = pwc_pkg::RESP_SLVERR;
            endcase
        end
        if (bvalid_r && s_axi_bready) begin
            bvalid_nxt = 1'b0;
        end
        // read channel
        do_rd = s_axi_arvalid && arready_r;
        if (do_rd) begin
            rvalid_nxt  = 1'b1;
            rresp_nxt   = pwc_pkg::RESP_OKAY;
            unique case (1'b1)
                hit(ar_a, pwc_pkg::OFF_MODE):
                    rdata_nxt = {21'h0, mode_r[6:4], 4'h0, mode_r[3:0]};
                hit(ar_a, pwc_pkg::OFF_DUTY):    rdata_nxt = 32'(duty_r);
                hit(ar_a, pwc_pkg::OFF_PERIOD):  rdata_nxt = 32'(period_r);
                hit(ar_a, pwc_pkg::OFF_COUNTER): rdata_nxt = 32'(cnt_r);
                hit(ar_a, pwc_pkg::OFF_UPDATE):  rdata_nxt = 32'h0000_0000;
                hit(ar_a, pwc_pkg::OFF_ENABLE):  rdata_nxt = {31'h0, en_r};
                hit(ar_a, pwc_pkg::OFF_DIVIDER): rdata_nxt = divider_r;
                hit(ar_a, pwc_pkg::OFF_FLAG): begin
                    rdata_nxt = {31'h0, flag_r};
                    flag_nxt  = 1'b0;
                end
                hit(ar_a, pwc_pkg::OFF_MASK):    rdata_nxt = {31'h0, mask_r};
                default: begin
                    rdata_nxt = 32'h0000_0000;
                    rresp_nxt = pwc_pkg::RESP_SLVERR;
                end
            endcase
        end
        if (rvalid_r && s_axi_rready) begin
            rvalid_nxt  = 1'b0;
        end
        // a period end in the same cycle as a clear keeps the flag
        if (boundary) begin
            flag_nxt = 1'b1;
        end
        awready_nxt = !aw_held_nxt;
        wready_nxt  = !w_held_nxt;
        // one read in flight: a new address is refused until the answer is taken
        arready_nxt = !rvalid_nxt;
        // opposite level from the duty match while the counter stays at or above the duty value
        out_nxt = mode_nxt.start_level_select ^ (en_nxt && cnt_nxt >= duty_nxt);
        irq_nxt = flag_nxt && mask_nxt;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_r    <= '0;
            dir_r     <= pwc_pkg::PWC_UP;
            duty_r    <= '0;
            period_r  <= '0;
            cnt_r     <= '0;
            upd_r     <= '0;
            pend_r    <= 1'b0;
            en_r      <= 1'b0;
            flag_r    <= 1'b0;
            mask_r    <= 1'b0;
            divider_r <= 32'h0000_0000;
            aw_held_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_held_r  <= 1'b0;
            w_data_r  <= 32'h0000_0000;
            w_strb_r  <= 4'h0;
            awready_r <= 1'b0;
            wready_r  <= 1'b0;
            bvalid_r  <= 1'b0;
            bresp_r   <= pwc_pkg::RESP_OKAY;
            arready_r <= 1'b0;
            rvalid_r  <= 1'b0;
            rdata_r   <= 32'h0000_0000;
            rresp_r   <= pwc_pkg::RESP_OKAY;
            out_r     <= 1'b0;
            irq_r     <= 1'b0;
        end else begin
            mode_r    <= mode_nxt;
            dir_r     <= dir_nxt;
            duty_r    <= duty_nxt;
            period_r  <= period_nxt;
            cnt_r     <= cnt_nxt;
            upd_r     <= upd_nxt;
            pend_r    <= pend_nxt;
            en_r      <= en_nxt;
            flag_r    <= flag_nxt;
            mask_r    <= mask_nxt;
            divider_r <= divider_nxt;
            aw_held_r <= aw_held_nxt;
            aw_addr_r <= aw_addr_nxt;
            w_held_r  <= w_held_nxt;
            w_data_r  <= w_data_nxt;
            w_strb_r  <= w_strb_nxt;
            awready_r <= awready_nxt;
            wready_r  <= wready_nxt;
            bvalid_r  <= bvalid_nxt;
            bresp_r   <= bresp_nxt;
            arready_r <= arready_nxt;
            rvalid_r  <= rvalid_nxt;
            rdata_r   <= rdata_nxt;
            rresp_r   <= rresp_nxt;
            out_r     <= out_nxt;
            irq_r     <= irq_nxt;
        end
    end

    assign s_axi_awready = awready_r;
    assign s_axi_wready  = wready_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;
    assign pwm_out       = out_r;
    assign irq           = irq_r;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    logic ena_wr;
    assign ena_wr = do_wr && hit(aw_addr_r, pwc_pkg::OFF_ENABLE) && wd[pwc_pkg::ENA_BIT];

    sequence s_enable_write;
        ena_wr;
    endsequence

    sequence s_update_armed;
        boundary && pend_r;
    endsequence

    chk_enable_clears_cnt: assert property (s_enable_write |=> cnt_r == '0)
        else $error("counter not cleared on enable");
    chk_left_wrap: assert property (tick && !mode_r.alignment_select && period_r != '0 &&
        cnt_r == period_r - CNT_W'(1) && !ena_wr |=> cnt_r == '0)
        else $error("left counter did not wrap at period");
    chk_left_range: assert property (en_r && !mode_r.alignment_select && $stable(period_r) &&
        period_r != '0 |-> cnt_r < period_r || $past(cnt_r) >= period_r)
        else $error("left counter beyond period");
    chk_center_turn: assert property (tick && mode_r.alignment_select && dir_r == pwc_pkg::PWC_UP
        && period_r > CNT_W'(1) && cnt_r == period_r && !ena_wr
        |=> dir_r == pwc_pkg::PWC_DOWN && cnt_r == $past(period_r) - CNT_W'(1))
        else $error("center counter did not turn down at period");
    chk_update_duty: assert property (s_update_armed and (!mode_r.update_target_select
        && !(do_wr && hit(aw_addr_r, pwc_pkg::OFF_DUTY))) |=> duty_r == $past(upd_r))
        else $error("buffered value not moved to duty");
    chk_update_period: assert property (s_update_armed and (mode_r.update_target_select
        && !(do_wr && hit(aw_addr_r, pwc_pkg::OFF_PERIOD))) |=> period_r == $past(upd_r))
        else $error("buffered value not moved to period");
    chk_no_mid_update: assert property (!boundary && !(do_wr && (hit(aw_addr_r, pwc_pkg::OFF_DUTY)
        || hit(aw_addr_r, pwc_pkg::OFF_PERIOD))) |=> $stable(duty_r) && $stable(period_r))
        else $error("duty or period changed in mid-period");
    chk_flag_set: assert property (boundary |=> flag_r)
        else $error("period flag not set");
    chk_flag_read_clear: assert property (do_rd && hit(ar_a, pwc_pkg::OFF_FLAG) && !boundary
        |=> !flag_r && rvalid_r)
        else $error("flag not cleared by read");
    chk_out_level: assert property (!en_r |-> pwm_out == $past(mode_nxt.start_level_select)
        || $past(en_nxt))
        else $error("idle output not at start level");
    // a settled divide-by-two that stalled for one cycle must step in the next
    chk_prescale_tick: assert property (en_r && $past(en_r)
        && mode_r.clock_divisor_select == 4'h1 && $past(mode_r.clock_divisor_select) == 4'h1
        && !ena_wr && !$past(ena_wr) && !mode_r.alignment_select && period_r > CNT_W'(2)
        && cnt_r < CNT_W'(2) && $stable(cnt_r) |=> cnt_r != $past(cnt_r))
        else $error("divide-by-two prescaler stalled twice");
    chk_shared_off: assert property (div_cfg[0].factor == pwc_pkg::FACTOR_OFF |-> !shared_tick[0])
        else $error("stopped shared clock ticked");
endmodule

// ==== tb/tb.sv ====
// self-checking testbench for the pwm channel waveform block
`timescale 1ns/1ps
module tb;
    logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, arvalid = 0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, got;
    logic [1:0]  bresp, rresp, resp;
    logic        awready, wready, bvalid, arready, rvalid, pwm_out, irq;
    int          n_errors = 0, n_compared = 0;
    always #2 aclk = ~aclk;
    // answer channels always ready, so every response is taken at once
    pwc_channel dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(1'b1), .pwm_out(pwm_out), .irq(irq));
    task automatic stop_test();
        $display("compared %0d, errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            n_errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw, w;
        aw = 0; w = 0;
        awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1;
        while (!(aw && w)) begin
            @(posedge aclk);
            aw = aw | awready;
            w = w | wready;
            awvalid <= !aw;
            wvalid <= !w;
        end
        do @(posedge aclk); while (!bvalid);
        resp = bresp;
    endtask
    task automatic chk(input logic [7:0] a, input logic [31:0] e);
        araddr <= a; arvalid <= 1;
        do @(posedge aclk); while (!arready);
        arvalid <= 0;
        do @(posedge aclk); while (!rvalid);
        got = rdata; resp = rresp;
        cmp(got, e);
    endtask
    task automatic t_regs();
        chk(pwc_pkg::OFF_UPDATE, 32'h0);
        chk(8'h24, 32'h0);
        cmp({30'h0, resp}, {30'h0, pwc_pkg::RESP_SLVERR});
        wr(8'h24, 32'h1);
        cmp({30'h0, resp}, {30'h0, pwc_pkg::RESP_SLVERR});
        wr(pwc_pkg::OFF_DUTY, 32'hffff0001);
        cmp({30'h0, resp}, {30'h0, pwc_pkg::RESP_OKAY});
        chk(pwc_pkg::OFF_DUTY, 32'h1);
        wr(pwc_pkg::OFF_PERIOD, 32'h4);
    endtask
    task automatic t_irq();
        wr(pwc_pkg::OFF_MASK, 32'h1);
        chk(pwc_pkg::OFF_FLAG, 32'h0);
        wr(pwc_pkg::OFF_ENABLE, 32'h1);
        repeat (8) @(posedge aclk);
        cmp({31'h0, irq}, 32'h1);
        chk(pwc_pkg::OFF_FLAG, 32'h1);
    endtask
    // high time and period in cycles: left, center, inverted, divide-by-2, shared a, shared b
    task automatic t_shape();
        int md[6] = '{32'h000, 32'h100, 32'h200, 32'h001, 32'h00b, 32'h00c};
        int pe[6] = '{4, 8, 4, 8, 12, 16};
        int hi[6] = '{3, 7, 1, 6, 9, 12};
        time t;
        // shared a: every tick divided by 3; shared b: every second tick divided by 2
        wr(pwc_pkg::OFF_DIVIDER, 32'h0102_0003);
        for (int i = 0; i < 6; i++) begin
            wr(pwc_pkg::OFF_MODE, 32'(md[i]));
            repeat (2) @(posedge pwm_out);
            @(posedge pwm_out);
            t = $time;
            @(negedge pwm_out);
            cmp(32'(($time - t) / 4), 32'(hi[i]));
            @(posedge pwm_out);
            cmp(32'(($time - t) / 4), 32'(pe[i]));
        end
    endtask
    // slowest divisor plus a counter restart keeps the boundary far from the writes
    task automatic t_buffer();
        wr(pwc_pkg::OFF_MODE, 32'h00a);
        wr(pwc_pkg::OFF_ENABLE, 32'h1);
        wr(pwc_pkg::OFF_UPDATE, 32'h3);
        chk(pwc_pkg::OFF_DUTY, 32'h1);
        repeat (4200) @(posedge aclk);
        chk(pwc_pkg::OFF_DUTY, 32'h3);
        wr(pwc_pkg::OFF_MODE, 32'h40a);
        wr(pwc_pkg::OFF_ENABLE, 32'h1);
        wr(pwc_pkg::OFF_UPDATE, 32'h8);
        chk(pwc_pkg::OFF_PERIOD, 32'h4);
        repeat (4200) @(posedge aclk);
        chk(pwc_pkg::OFF_PERIOD, 32'h8);
    endtask
    initial begin
        repeat (40000) @(posedge aclk);
        n_errors++;
        stop_test();
    end
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        t_regs();
        t_irq();
        t_shape();
        t_buffer();
        stop_test();
    end
endmodule
